//--- pts_msr_bank.sv
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
// power, thermal and debug register bank behind an apb slave
`include "pts_defs.svh"
module pts_msr_bank
  import pts_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins from outside the clock domain
  input wire logic turbo_strap,
  input wire logic [7:0] die_temp,
  input wire logic pkg_asleep,
  input wire logic core_asleep,
  // core events on this clock
  input wire logic timestamp_tick,
  input wire logic branch_taken,
  input wire logic [63:0] branch_from,
  input wire logic [63:0] branch_to,
  input wire logic fault_taken,
  input wire logic [2:0] fixed_event,
  input wire logic mc_capture,
  input wire logic [63:0] mc_addr_in,
  // status outputs
  output logic dynamic_accel_flag,
  output logic hot_signal_out,
  output logic throttle_active,
  output logic precise_sampling
);
  localparam logic [11:0] LBRF = `PTS_IDX_LBRF;
  localparam logic [11:0] LBRT = `PTS_IDX_LBRT;

  // register index decode, shared by the read and the write path
  function automatic pts_sel_t pts_decode(input logic [31:0] a);
    logic [11:0] i;
    i = a[13:2];
    pts_decode = SEL_NONE;
    if (a[31:15] == 17'h0_0000 && a[1:0] == 2'h0) begin
      unique case (i)
        `PTS_IDX_FEAT: pts_decode = SEL_FEAT;
        `PTS_IDX_TRIP: pts_decode = SEL_TRIP;
        `PTS_IDX_OFF0: pts_decode = SEL_OFF0;
        `PTS_IDX_OFF1: pts_decode = SEL_OFF1;
        `PTS_IDX_RATIO: pts_decode = SEL_RATIO;
        `PTS_IDX_TOP: pts_decode = SEL_TOP;
        `PTS_IDX_DBG: pts_decode = SEL_DBG;
        `PTS_IDX_LERF: pts_decode = SEL_LERF;
        `PTS_IDX_LERT: pts_decode = SEL_LERT;
        `PTS_IDX_MEMK: pts_decode = SEL_MEMK;
        `PTS_IDX_FIX0, `PTS_IDX_FIX1, `PTS_IDX_FIX2: pts_decode = SEL_FIX;
        `PTS_IDX_FCTL: pts_decode = SEL_FCTL;
        `PTS_IDX_SAMP: pts_decode = SEL_SAMP;
        `PTS_IDX_PKG6: pts_decode = SEL_PKG6;
        `PTS_IDX_CORE6: pts_decode = SEL_CORE6;
        `PTS_IDX_MC4S: pts_decode = SEL_MCST;
        `PTS_IDX_MC4A: pts_decode = SEL_MCAD;
        `PTS_IDX_MC0A, `PTS_IDX_MC2A, `PTS_IDX_MC3A, `PTS_IDX_MC5A: pts_decode = SEL_GP;
        default: begin
          if (i[11:3] == LBRF[11:3]) pts_decode = SEL_LBRF;
          else if (i[11:3] == LBRT[11:3]) pts_decode = SEL_LBRT;
        end
      endcase
    end
  endfunction : pts_decode

  // merge a 32-bit write into one half of a 64-bit register
  function automatic pts_word_t pts_merge(input pts_word_t old, input logic hi,
                                          input logic [31:0] d);
    pts_merge = hi ? {d, old[31:0]} : {old[63:32], d};
  endfunction : pts_merge

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] strap_sync_q;
  logic [7:0] temp_meta_q;
  logic [7:0] temp_q;
  logic [1:0] pkg_sync_q;
  logic [1:0] core_sync_q;
  logic [1:0] strap_cnt_q;
  logic turbo_cap_q;
  logic turbo_dis_q;
  logic [5:0] trip_off_q;
  pts_word_t off0_q;
  pts_word_t off1_q;
  logic [31:0] ratio_q;
  logic [2:0] top_q;
  pts_word_t dbg_q;
  pts_word_t ler_from_q;
  pts_word_t ler_to_q;
  pts_word_t memk_q;
  pts_word_t fix_q [3];
  pts_word_t fctl_q;
  logic samp_q;
  logic mc_valid_q;
  pts_word_t mc_addr_q;
  pts_word_t lbr_from_q [8];
  pts_word_t lbr_to_q [8];
  pts_word_t pkg_time;
  pts_word_t core_time;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic accel_q;
  logic hot_q;
  pts_sel_t sel;
  logic hi;
  logic wr_en;
  logic [2:0] ent;
  logic [1:0] fix_n;
  logic [8:0] trip_level;
  logic trip_hit;
  logic rec_en;
  pts_word_t rd64;

  // reset release through two flops; assertion is immediate
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // two-flop synchronisers for every pin input
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_sync_q <= 2'h0;
      temp_meta_q <= 8'h00;
      temp_q <= 8'h00;
      pkg_sync_q <= 2'h0;
      core_sync_q <= 2'h0;
    end else begin
      strap_sync_q <= {strap_sync_q[0], turbo_strap};
      temp_meta_q <= die_temp; // sensor value moves slowly, skew is harmless
      temp_q <= temp_meta_q;
      pkg_sync_q <= {pkg_sync_q[0], pkg_asleep};
      core_sync_q <= {core_sync_q[0], core_asleep};
    end
  end

  assign sel = pts_decode(paddr);
  assign hi = paddr[`PTS_HI_BIT];
  assign wr_en = psel && penable && pready_q && pwrite;
  assign ent = paddr[4:2];
  assign fix_n = paddr[3:2] - 2'h1;
  assign rec_en = dbg_q[`PTS_LBR_EN_BIT];

  // strap caught once the synchroniser has settled after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_q <= 2'h0;
      turbo_cap_q <= 1'b0;
      turbo_dis_q <= 1'b0;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2) begin
        turbo_cap_q <= strap_sync_q[1];
        turbo_dis_q <= strap_sync_q[1];
      end
    end else if (wr_en && sel == SEL_FEAT && hi) begin
      turbo_dis_q <= pwdata[`PTS_TURBO_DIS_BIT - 32];
    end
  end

  // accel flag: set only with turbo hardware present and not disabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) accel_q <= 1'b0;
    else accel_q <= turbo_cap_q && !turbo_dis_q;
  end

  // thermal trip: default target plus programmed offset, nine bits wide
  assign trip_level = {1'b0, `PTS_TRIP_TARGET} + {3'h0, trip_off_q};
  assign trip_hit = {1'b0, temp_q} >= trip_level;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trip_off_q <= 6'h00;
      hot_q <= 1'b0;
    end else begin
      hot_q <= trip_hit;
      if (wr_en && sel == SEL_TRIP && !hi) trip_off_q <= pwdata[29:24];
    end
  end

  // plain software registers; reserved bits are never stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      off0_q <= `PTS_ZERO64;
      off1_q <= `PTS_ZERO64;
      ratio_q <= 32'h0000_0000;
      dbg_q <= `PTS_ZERO64;
      memk_q <= `PTS_ZERO64;
      fctl_q <= `PTS_ZERO64;
      samp_q <= 1'b0;
    end else if (wr_en) begin
      unique case (sel)
        SEL_OFF0: off0_q <= pts_merge(off0_q, hi, pwdata);
        SEL_OFF1: off1_q <= pts_merge(off1_q, hi, pwdata);
        SEL_RATIO: if (!hi) ratio_q <= pwdata;
        SEL_DBG: dbg_q <= pts_merge(dbg_q, hi, pwdata);
        SEL_MEMK: memk_q <= pts_merge(memk_q, hi, pwdata);
        SEL_FCTL: fctl_q <= pts_merge(fctl_q, hi, pwdata);
        SEL_SAMP: if (!hi) samp_q <= pwdata[0];
        default: ;
      endcase
    end
  end

  // fixed counters: a software write takes the place of that cycle's count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int n = 0; n < 3; n++) fix_q[n] <= `PTS_ZERO64;
    end else begin
      for (int n = 0; n < 3; n++) begin
        if (wr_en && sel == SEL_FIX && fix_n == n[1:0]) begin
          fix_q[n] <= pts_merge(fix_q[n], hi, pwdata);
        end else if (fixed_event[n] && fctl_q[4*n +: 2] != 2'h0) begin
          fix_q[n] <= fix_q[n] + 64'h0000_0000_0000_0001;
        end
      end
    end
  end

  // branch stack: a recorded branch wins over a software write that cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      top_q <= 3'h0;
      for (int n = 0; n < 8; n++) begin
        lbr_from_q[n] <= `PTS_ZERO64;
        lbr_to_q[n] <= `PTS_ZERO64;
      end
    end else if (branch_taken && rec_en) begin
      top_q <= top_q + 3'h1;
      lbr_from_q[top_q + 3'h1] <= branch_from;
      lbr_to_q[top_q + 3'h1] <= branch_to;
    end else if (wr_en) begin
      if (sel == SEL_TOP && !hi) top_q <= pwdata[2:0];
      if (sel == SEL_LBRF) lbr_from_q[ent] <= pts_merge(lbr_from_q[ent], hi, pwdata);
      if (sel == SEL_LBRT) lbr_to_q[ent] <= pts_merge(lbr_to_q[ent], hi, pwdata);
    end
  end

  // fault record: copy the newest branch entry when a fault is taken
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ler_from_q <= `PTS_ZERO64;
      ler_to_q <= `PTS_ZERO64;
    end else if (fault_taken) begin
      ler_from_q <= lbr_from_q[top_q];
      ler_to_q <= lbr_to_q[top_q];
    end
  end

  // machine-check address log; a capture beats a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mc_valid_q <= 1'b0;
      mc_addr_q <= `PTS_ZERO64;
    end else if (mc_capture) begin
      mc_valid_q <= 1'b1;
      mc_addr_q <= mc_addr_in;
    end else if (wr_en && sel == SEL_MCST && hi && !pwdata[`PTS_VALID_BIT - 32]) begin
      mc_valid_q <= 1'b0;
    end
  end

  // residency counters run on the synchronised sleep levels
  pts_residency_ctr u_pkg_time (
    .mclk(mclk),
    .rst_n(rst_n),
    .asleep(pkg_sync_q[1]),
    .tick(timestamp_tick),
    .count(pkg_time)
  );
  pts_residency_ctr u_core_time (
    .mclk(mclk),
    .rst_n(rst_n),
    .asleep(core_sync_q[1]),
    .tick(timestamp_tick),
    .count(core_time)
  );

  // read view of the selected register, reserved bits forced to zero
  always_comb begin
    rd64 = `PTS_ZERO64;
    unique case (sel)
      SEL_FEAT: rd64[`PTS_TURBO_DIS_BIT] = turbo_dis_q;
      SEL_TRIP: rd64[29:16] = {trip_off_q, `PTS_TRIP_TARGET};
      SEL_OFF0: rd64 = off0_q;
      SEL_OFF1: rd64 = off1_q;
      SEL_RATIO: rd64[31:0] = ratio_q;
      SEL_TOP: rd64[2:0] = top_q;
      SEL_DBG: rd64 = dbg_q;
      SEL_LERF: rd64 = ler_from_q;
      SEL_LERT: rd64 = ler_to_q;
      SEL_MEMK: rd64 = memk_q;
      SEL_FIX: rd64 = fix_q[fix_n];
      SEL_FCTL: rd64 = fctl_q;
      SEL_SAMP: rd64[0] = samp_q;
      SEL_PKG6: rd64 = pkg_time;
      SEL_CORE6: rd64 = core_time;
      SEL_MCST: rd64[`PTS_VALID_BIT] = mc_valid_q;
      SEL_MCAD: rd64 = mc_valid_q ? mc_addr_q : `PTS_ZERO64;
      SEL_LBRF: rd64 = lbr_from_q[ent];
      SEL_LBRT: rd64 = lbr_to_q[ent];
      default: rd64 = `PTS_ZERO64;
    endcase
  end

  // apb answer: data and error latched in setup, ready in the access cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
      if (psel && !penable) begin
        prdata_q <= pwrite ? 32'h0000_0000 : (hi ? rd64[63:32] : rd64[31:0]);
        pslverr_q <= sel == SEL_NONE || sel == SEL_GP;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dynamic_accel_flag = accel_q;
  assign hot_signal_out = hot_q;
  assign throttle_active = hot_q;
  assign precise_sampling = samp_q;

  a_turbo_flag_off: assert property (@(posedge mclk) disable iff (!rst_n)
    turbo_dis_q |=> !dynamic_accel_flag) else $error("accel flag set while disabled");
  a_turbo_flag_on: assert property (@(posedge mclk) disable iff (!rst_n)
    turbo_cap_q && !turbo_dis_q |=> dynamic_accel_flag) else $error("accel flag missing");
  a_strap_default: assert property (@(posedge mclk) disable iff (!rst_n)
    strap_cnt_q == 2'h2 |=> turbo_dis_q == turbo_cap_q) else $error("strap not taken");
  a_target_read: assert property (@(posedge mclk) disable iff (!rst_n)
    psel && !penable && !pwrite && sel == SEL_TRIP && !hi
    |=> prdata[23:16] == `PTS_TRIP_TARGET) else $error("target field wrong");
  a_hot_trip: assert property (@(posedge mclk) disable iff (!rst_n)
    trip_hit |=> hot_signal_out && throttle_active) else $error("hot signal late");
  a_top_step: assert property (@(posedge mclk) disable iff (!rst_n)
    branch_taken && rec_en |=> top_q == $past(top_q) + 3'h1) else $error("stack top stuck");
  a_ler_capture: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_taken |=> ler_to_q == $past(lbr_to_q[top_q])) else $error("fault target lost");
  a_samp_write: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_en && sel == SEL_SAMP && !hi |=> precise_sampling == $past(pwdata[0]))
    else $error("sampling enable not stored");
  a_pkg_count: assert property (@(posedge mclk) disable iff (!rst_n)
    pkg_sync_q[1] && timestamp_tick |=> pkg_time == $past(pkg_time) + 64'h0000_0000_0000_0001)
    else $error("package residency not counting");
  a_mc_hidden: assert property (@(posedge mclk) disable iff (!rst_n)
    psel && !penable && !pwrite && sel == SEL_MCAD && !mc_valid_q && !mc_capture
    |=> prdata == 32'h0000_0000) else $error("address shown while invalid");
  a_gp_error: assert property (@(posedge mclk) disable iff (!rst_n)
    psel && !penable && sel == SEL_GP |=> pready && pslverr) else $error("no fault");
endmodule : pts_msr_bank

//--- pts_defs.svh
// register indices, field positions and reset values of the msr bank
// Summary of operation
// - writing turbo-disable bit 38 as 1 stops turbo and clears the accel flag
// - turbo-disable bit at 0 reports turbo as enabled through the accel flag when turbo hardware is present
// - power-on value of turbo-disable is 1 with turbo hardware, 0 without
// - read-only bits 23:16 give the default throttle and hot temperature
// - writable bits 29:24 hold an offset to the activation temperature
// - throttle and hot signal trip at default target plus offset
// - four 8-bit ratio caps for one to four active cores, upper half reserved
// - 3-bit stack top index in bits 2:0 points at the newest branch entry
// - read-only source of the last branch before the latest fault
// - read-only target of the last branch before the latest fault
// - bit 0 of the sampling enable turns on precise sampling on counter 0
// - read-only 64-bit package deep-sleep time, counts timestamp ticks
// - read-only 64-bit core deep-sleep time, counts timestamp ticks
// - machine-check address reads as no address while valid flag is clear
// - unimplemented machine-check address registers fault any access
// - three writable fixed counters at consecutive indices from 309h
// - eight read-write branch target entries beside eight source entries
`ifndef PTS_DEFS_SVH
`define PTS_DEFS_SVH
// register indices; byte address is index times four, bit 14 picks the upper half
`define PTS_HI_BIT 14
`define PTS_IDX_LBRF 12'h040
`define PTS_IDX_LBRT 12'h060
`define PTS_IDX_FEAT 12'h1a0
`define PTS_IDX_TRIP 12'h1a2
`define PTS_IDX_OFF0 12'h1a6
`define PTS_IDX_OFF1 12'h1a7
`define PTS_IDX_RATIO 12'h1ad
`define PTS_IDX_TOP 12'h1c9
`define PTS_IDX_DBG 12'h1d9
`define PTS_IDX_LERF 12'h1dd
`define PTS_IDX_LERT 12'h1de
`define PTS_IDX_MEMK 12'h2ff
`define PTS_IDX_FIX0 12'h309
`define PTS_IDX_FIX1 12'h30a
`define PTS_IDX_FIX2 12'h30b
`define PTS_IDX_FCTL 12'h38d
`define PTS_IDX_SAMP 12'h3f1
`define PTS_IDX_PKG6 12'h3fa
`define PTS_IDX_CORE6 12'h3fd
`define PTS_IDX_MC0A 12'h402
`define PTS_IDX_MC2A 12'h40a
`define PTS_IDX_MC3A 12'h40e
`define PTS_IDX_MC4S 12'h411
`define PTS_IDX_MC4A 12'h412
`define PTS_IDX_MC5A 12'h416
// field positions
`define PTS_TURBO_DIS_BIT 38
`define PTS_VALID_BIT 58
`define PTS_LBR_EN_BIT 0
// reset values
`define PTS_TRIP_TARGET 8'h5a
`define PTS_ZERO64 64'h0000_0000_0000_0000
`endif

//--- pts_pkg.sv
// types shared by the msr bank modules
package pts_pkg;
  typedef logic [63:0] pts_word_t;
  typedef enum logic [4:0] {
    SEL_NONE = 5'h00, SEL_FEAT = 5'h01, SEL_TRIP = 5'h02, SEL_OFF0 = 5'h03,
    SEL_OFF1 = 5'h04, SEL_RATIO = 5'h05, SEL_TOP = 5'h06, SEL_DBG = 5'h07,
    SEL_LERF = 5'h08, SEL_LERT = 5'h09, SEL_MEMK = 5'h0a, SEL_FIX = 5'h0b,
    SEL_FCTL = 5'h0c, SEL_SAMP = 5'h0d, SEL_PKG6 = 5'h0e, SEL_CORE6 = 5'h0f,
    SEL_MCST = 5'h10, SEL_MCAD = 5'h11, SEL_LBRF = 5'h12, SEL_LBRT = 5'h13,
    SEL_GP = 5'h14
  } pts_sel_t;
endpackage : pts_pkg

//--- pts_residency_ctr.sv
`timescale 1ns/10ps
// deep-sleep residency counter advancing on timestamp ticks
`include "pts_defs.svh"
module pts_residency_ctr
  import pts_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // count condition
  input wire logic asleep,
  input wire logic tick,
  // running total
  output pts_word_t count
);
  pts_word_t cnt_q;

  // counts only while asleep; never cleared except by reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `PTS_ZERO64;
    end else if (asleep && tick) begin
      cnt_q <= cnt_q + 64'h0000_0000_0000_0001;
    end
  end

  assign count = cnt_q;
endmodule : pts_residency_ctr

//--- tb_top.sv
`timescale 1ns/10ps
// self-checking bench for the power, thermal and debug register bank
`include "pts_defs.svh"
module tb_top
  import pts_pkg::*;
;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic turbo_strap = 1'b1;
  logic [7:0] die_temp = 8'h00;
  logic pkg_asleep = 1'b0, core_asleep = 1'b0, timestamp_tick = 1'b0;
  logic branch_taken = 1'b0, fault_taken = 1'b0, mc_capture = 1'b0;
  logic [63:0] branch_from = 64'h0000_0000_0000_0000, branch_to = 64'h0000_0000_0000_0000;
  logic [63:0] mc_addr_in = 64'h0000_0000_0000_0000;
  logic [2:0] fixed_event = 3'h0;
  logic dynamic_accel_flag, hot_signal_out, throttle_active, precise_sampling;
  int error_cnt = 0;
  int comparisons = 0;

  // 100 ns period
  always #50 mclk = ~mclk;

  pts_msr_bank DUT (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .turbo_strap(turbo_strap), .die_temp(die_temp),
    .pkg_asleep(pkg_asleep), .core_asleep(core_asleep), .timestamp_tick(timestamp_tick),
    .branch_taken(branch_taken), .branch_from(branch_from), .branch_to(branch_to),
    .fault_taken(fault_taken), .fixed_event(fixed_event), .mc_capture(mc_capture),
    .mc_addr_in(mc_addr_in), .dynamic_accel_flag(dynamic_accel_flag),
    .hot_signal_out(hot_signal_out), .throttle_active(throttle_active),
    .precise_sampling(precise_sampling));

  task automatic wrap_up;
    $display("counts: %0d compares, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %b expected %b", $time, m, got, exp);
    end
  endtask : chk1

  function automatic logic [31:0] ad(input logic [11:0] i, input logic h);
    return {17'h0_0000, h, i, 2'b00};
  endfunction : ad

  // one apb transfer; entered and left on a rising edge, idle cycle after release
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] v, output logic e);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk1(1'b0, 1'b1, "pready timeout");
    v = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [11:0] i, input logic h, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, ad(i, h), d, v, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] i, input logic h, input logic [31:0] exp,
                        input string m);
    logic [31:0] v;
    logic e;
    apb(1'b0, ad(i, h), 32'h0000_0000, v, e);
    chk32(v, exp, m);
    chk1(e, 1'b0, "no error on mapped read");
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // one-cycle timestamp pulses with a quiet cycle between them
  task automatic ticks(input int n);
    repeat (n) begin
      timestamp_tick <= 1'b1;
      cyc(1);
      timestamp_tick <= 1'b0;
      cyc(1);
    end
  endtask : ticks

  // strap gives turbo capability; disable bit drives the accel flag
  task automatic t_turbo;
    rd_chk(`PTS_IDX_FEAT, 1'b1, 32'h0000_0040, "turbo disable default");
    chk1(dynamic_accel_flag, 1'b0, "flag while disabled");
    wr(`PTS_IDX_FEAT, 1'b1, 32'h0000_0000);
    cyc(2);
    chk1(dynamic_accel_flag, 1'b1, "flag with turbo enabled");
    wr(`PTS_IDX_FEAT, 1'b1, 32'hffff_ffff);
    cyc(2);
    chk1(dynamic_accel_flag, 1'b0, "flag after disable");
    rd_chk(`PTS_IDX_FEAT, 1'b1, 32'h0000_0040, "reserved upper bits");
    $display("test turbo done");
  endtask : t_turbo

  // target is fixed, offset is writable, trip at target plus offset
  task automatic t_thermal;
    rd_chk(`PTS_IDX_TRIP, 1'b0, 32'h005a_0000, "trip target");
    wr(`PTS_IDX_TRIP, 1'b0, 32'hffff_ffff);
    rd_chk(`PTS_IDX_TRIP, 1'b0, 32'h3f5a_0000, "trip offset and reserved");
    rd_chk(`PTS_IDX_TRIP, 1'b1, 32'h0000_0000, "trip upper reserved");
    wr(`PTS_IDX_TRIP, 1'b0, 32'h0500_0000);
    die_temp <= 8'h5e;
    cyc(6);
    chk1(hot_signal_out, 1'b0, "hot one below trip");
    die_temp <= 8'h5f;
    cyc(6);
    chk1(hot_signal_out, 1'b1, "hot at trip");
    chk1(throttle_active, 1'b1, "throttle at trip");
    die_temp <= 8'h00;
    $display("test thermal done");
  endtask : t_thermal

  // four ratio caps in the low word, upper word reserved
  task automatic t_ratio;
    wr(`PTS_IDX_RATIO, 1'b0, 32'h1234_5678);
    wr(`PTS_IDX_RATIO, 1'b1, 32'hffff_ffff);
    rd_chk(`PTS_IDX_RATIO, 1'b0, 32'h1234_5678, "ratio caps");
    rd_chk(`PTS_IDX_RATIO, 1'b1, 32'h0000_0000, "ratio reserved");
    $display("test ratio done");
  endtask : t_ratio

  // branch recording only while enabled, fault copies newest entry
  task automatic t_branch;
    logic [31:0] v;
    logic e;
    logic [2:0] t;
    apb(1'b0, ad(`PTS_IDX_TOP, 1'b0), 32'h0000_0000, v, e);
    t = v[2:0];
    chk32(v & 32'hffff_fff8, 32'h0000_0000, "stack top reserved");
    branch_from <= 64'h0000_0011_2233_4455; branch_to <= 64'h0000_0066_7788_99aa;
    branch_taken <= 1'b1;
    cyc(1);
    branch_taken <= 1'b0;
    rd_chk(`PTS_IDX_TOP, 1'b0, {29'h0, t}, "stack top while disabled");
    wr(`PTS_IDX_DBG, 1'b0, 32'h0000_0001);
    branch_taken <= 1'b1;
    cyc(1);
    branch_taken <= 1'b0;
    t = t + 3'd1;
    rd_chk(`PTS_IDX_TOP, 1'b0, {29'h0, t}, "stack top advance");
    rd_chk(`PTS_IDX_LBRF + {9'h0, t}, 1'b0, 32'h2233_4455, "branch source");
    rd_chk(`PTS_IDX_LBRT + {9'h0, t}, 1'b0, 32'h7788_99aa, "branch target");
    rd_chk(`PTS_IDX_LBRT + {9'h0, t}, 1'b1, 32'h0000_0066, "branch target high");
    wr(`PTS_IDX_LBRT + {9'h0, t}, 1'b0, 32'hcafe_0001);
    rd_chk(`PTS_IDX_LBRT + {9'h0, t}, 1'b0, 32'hcafe_0001, "branch target write");
    fault_taken <= 1'b1;
    cyc(1);
    fault_taken <= 1'b0;
    rd_chk(`PTS_IDX_LERF, 1'b0, 32'h2233_4455, "fault source");
    rd_chk(`PTS_IDX_LERF, 1'b1, 32'h0000_0011, "fault source high");
    wr(`PTS_IDX_LERT, 1'b0, 32'h0000_0000);
    rd_chk(`PTS_IDX_LERT, 1'b0, 32'hcafe_0001, "fault target read-only");
    $display("test branch done");
  endtask : t_branch

  // precise sampling follows bit 0
  task automatic t_sampling;
    wr(`PTS_IDX_SAMP, 1'b0, 32'h0000_0001);
    cyc(2);
    chk1(precise_sampling, 1'b1, "sampling on");
    wr(`PTS_IDX_SAMP, 1'b0, 32'h0000_0000);
    cyc(2);
    chk1(precise_sampling, 1'b0, "sampling off");
    $display("test sampling done");
  endtask : t_sampling

  // residency counters advance only on ticks while asleep
  task automatic t_residency;
    ticks(2);
    pkg_asleep <= 1'b1;
    cyc(4);
    ticks(5);
    pkg_asleep <= 1'b0;
    core_asleep <= 1'b1;
    cyc(4);
    ticks(3);
    core_asleep <= 1'b0;
    cyc(4);
    wr(`PTS_IDX_PKG6, 1'b0, 32'hffff_ffff);
    rd_chk(`PTS_IDX_PKG6, 1'b0, 32'h0000_0005, "package sleep time");
    rd_chk(`PTS_IDX_PKG6, 1'b1, 32'h0000_0000, "package sleep time high");
    rd_chk(`PTS_IDX_CORE6, 1'b0, 32'h0000_0003, "core sleep time");
    $display("test residency done");
  endtask : t_residency

  // capture sets the valid flag; missing address registers and holes are refused
  task automatic t_mcheck;
    logic [31:0] v;
    logic e;
    logic [11:0] gp [5];
    gp = '{`PTS_IDX_MC0A, `PTS_IDX_MC2A, `PTS_IDX_MC3A, `PTS_IDX_MC5A, 12'h123};
    rd_chk(`PTS_IDX_MC4S, 1'b1, 32'h0000_0000, "valid flag clear");
    mc_addr_in <= 64'h0000_00ab_cdef_0123;
    mc_capture <= 1'b1;
    cyc(1);
    mc_capture <= 1'b0;
    rd_chk(`PTS_IDX_MC4S, 1'b1, 32'h0400_0000, "valid flag set");
    rd_chk(`PTS_IDX_MC4A, 1'b0, 32'hcdef_0123, "captured address");
    wr(`PTS_IDX_MC4S, 1'b1, 32'h0000_0000);
    rd_chk(`PTS_IDX_MC4S, 1'b1, 32'h0000_0000, "valid flag cleared");
    rd_chk(`PTS_IDX_MC4A, 1'b0, 32'h0000_0000, "address hidden while invalid");
    foreach (gp[k]) begin
      apb(1'b0, ad(gp[k], 1'b0), 32'h0000_0000, v, e);
      chk1(e, 1'b1, "read of missing register");
      apb(1'b1, ad(gp[k], 1'b1), 32'h0000_0000, v, e);
      chk1(e, 1'b1, "write of missing register");
    end
    $display("test machine check done");
  endtask : t_mcheck

  // three writable fixed counters, only enabled ones count events
  task automatic t_fixed;
    for (int k = 0; k < 3; k++) wr(`PTS_IDX_FIX0 + 12'(k), 1'b0, 32'h0000_0010 + k);
    wr(`PTS_IDX_FCTL, 1'b0, 32'h0000_0001);
    fixed_event <= 3'b111;
    cyc(1);
    fixed_event <= 3'b000;
    rd_chk(`PTS_IDX_FIX0, 1'b0, 32'h0000_0011, "fixed counter 0");
    rd_chk(`PTS_IDX_FIX1, 1'b0, 32'h0000_0011, "fixed counter 1");
    rd_chk(`PTS_IDX_FIX2, 1'b0, 32'h0000_0012, "fixed counter 2");
    $display("test fixed counters done");
  endtask : t_fixed

  // second reset in mid-run with the strap low: no turbo hardware present
  task automatic t_no_turbo;
    turbo_strap <= 1'b0;
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    cyc(6);
    rd_chk(`PTS_IDX_FEAT, 1'b1, 32'h0000_0000, "disable default without hardware");
    rd_chk(`PTS_IDX_TRIP, 1'b0, 32'h005a_0000, "offset cleared by reset");
    wr(`PTS_IDX_FEAT, 1'b1, 32'h0000_0000);
    cyc(2);
    chk1(dynamic_accel_flag, 1'b0, "flag without turbo hardware");
    $display("test second reset done");
  endtask : t_no_turbo

  // watchdog sized well beyond the expected run of about two hundred and fifty cycles
  initial begin
    #2_000_000;
    error_cnt++;
    $display("wrong value at %0t: run did not finish", $time);
    wrap_up();
  end

  // main sequence
  initial begin
    cyc(6);
    arst_n <= 1'b1;
    cyc(6);
    t_turbo();
    t_thermal();
    t_ratio();
    t_branch();
    t_sampling();
    t_residency();
    t_mcheck();
    t_fixed();
    t_no_turbo();
    wrap_up();
  end
endmodule : tb_top
